//--- hdl/emsp_cfg.svh
// Constants for the serial EEPROM status and protection link
`ifndef EMSP_CFG_SVH
`define EMSP_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define EMSP_CLK_PERIOD_NS 40
`define EMSP_SCK_PERIOD_NS 320
`define EMSP_SCK_HALF_CYC  (`EMSP_SCK_PERIOD_NS / (2 * `EMSP_CLK_PERIOD_NS))
`define EMSP_WRITE_TIME_US 4000
`define EMSP_WRITE_CYC     ((`EMSP_WRITE_TIME_US * 1000) / `EMSP_CLK_PERIOD_NS)

// ----------------------------------------
// Instruction codes (low three bits)
// ----------------------------------------
`define EMSP_OP_SET_LATCH  3'h6
`define EMSP_OP_CLR_LATCH  3'h4
`define EMSP_OP_RD_STAT    3'h5
`define EMSP_OP_WR_STATUS  3'h1

// ----------------------------------------
// Status register layout and reset
// ----------------------------------------
`define EMSP_SR_BUSY       0
`define EMSP_SR_LATCH      1
`define EMSP_SR_BP_LO      2
`define EMSP_SR_BP_HI      3
`define EMSP_SR_HWPE       7
`define EMSP_SR_BUSY_VIEW  8'hFF
`define EMSP_BP_RST        2'h0
`define EMSP_HWPE_RST      1'b0
`define EMSP_QTR_BASE      10'h300
`define EMSP_HALF_BASE     10'h200

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define EMSP_REG_CMD       4'h0
`define EMSP_REG_STAT      4'h4
`define EMSP_REG_PINS      4'h8
`define EMSP_CMD_LONG      16
`define EMSP_STAT_BUSY     0
`define EMSP_STAT_RX_LSB   8
`define EMSP_PINS_WP       0
`define EMSP_PINS_HOLD     1
`define EMSP_PINS_RST      2'h3
`define EMSP_RESP_OK       2'h0
`define EMSP_RESP_ERR      2'h2

`endif

//--- hdl/emsp_pkg.sv
// Types of the serial EEPROM link: host end states and EEPROM end write kinds
package emsp_pkg;

	typedef enum logic [1:0] {
		HST_IDLE,
		HST_RUN,
		HST_GAP,
		HST_TAIL
	} emsp_host_state_t;

	typedef enum logic {
		WK_STATUS,
		WK_ARRAY
	} emsp_wkind_t;

endpackage

//--- hdl/emsp_link_if.sv
// Serial link between the bus master controller and the EEPROM end
`timescale 1ns/1ps
interface emsp_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic hold_n;
	logic wp_n;
	logic so;
	logic so_oe;
	logic so_line;

	// Released output line floats high
	assign so_line = so_oe ? so : 1'b1;

	modport dev (
		input  cs_n,
		input  sck,
		input  si,
		input  hold_n,
		input  wp_n,
		output so,
		output so_oe
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		output hold_n,
		output wp_n,
		input  so_line
	);
endinterface

//--- hdl/emsp_sync_edge.sv
// Two-stage synchroniser with edge detection
`timescale 1ns/1ps
module emsp_sync_edge #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_n,
	// Asynchronous inputs
	input  wire logic [W-1:0] i_async,
	// Synchronised level and edges
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			prev_q <= RST_VAL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_level = sync_q;
	assign o_rise  = sync_q & ~prev_q;
	assign o_fall  = ~sync_q & prev_q;
endmodule

//--- hdl/emsp_dev_end.sv
// EEPROM end: serial front end, status register and protection
`timescale 1ns/1ps
`include "emsp_cfg.svh"
module emsp_dev_end #(
	parameter int P_WRITE_CYCLES = `EMSP_WRITE_CYC
) (
	// Clock and power-on reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Serial link
	emsp_link_if.dev        lnk,
	// Array sequencer side
	input  wire logic       i_arr_req,
	input  wire logic [9:0] i_arr_addr,
	output logic            o_arr_go,
	// Status view
	output logic            o_busy,
	output logic            o_hw_protect,
	output logic      [7:0] o_status
);
	localparam int IX_CS   = 0;
	localparam int IX_SCK  = 1;
	localparam int IX_SI   = 2;
	localparam int IX_HOLD = 3;
	localparam int IX_WP   = 4;
	localparam int WCW     = $clog2(P_WRITE_CYCLES);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic op_is(input logic [7:0] op, input logic [2:0] code);
		op_is = (op[7:4] == 4'h0) && (op[2:0] == code);
	endfunction

	function automatic logic in_block(input logic [1:0] bp, input logic [9:0] addr);
		unique case (bp)
			2'h0: in_block = 1'b0;
			2'h1: in_block = (addr >= `EMSP_QTR_BASE);
			2'h2: in_block = (addr >= `EMSP_HALF_BASE);
			2'h3: in_block = 1'b1;
		endcase
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_lvl;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;

	emsp_sync_edge #(
		.W       (5),
		.RST_VAL (5'h19)
	) u_pins (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_async    ({lnk.wp_n, lnk.hold_n, lnk.si, lnk.sck, lnk.cs_n}),
		.o_level    (pin_lvl),
		.o_rise     (pin_rise),
		.o_fall     (pin_fall)
	);

	logic cs_low;
	logic held;
	logic sck_rise;
	logic sck_fall;
	logic frame_end;
	logic hw_prot;

	assign cs_low    = ~pin_lvl[IX_CS];
	assign held      = ~pin_lvl[IX_HOLD];
	assign sck_rise  = pin_rise[IX_SCK] & cs_low & ~held;
	assign sck_fall  = pin_fall[IX_SCK] & cs_low & ~held;
	assign frame_end = pin_rise[IX_CS];

	// ----------------------------------------
	// State declarations
	// ----------------------------------------
	logic [4:0]          bitcnt_q;
	logic [7:0]          op_q;
	logic [7:0]          dat_q;
	logic [7:0]          sout_q;
	logic                rdout_q;
	logic                latch_q;
	logic [1:0]          bp_q;
	logic                hwpe_q;
	logic                busy_q;
	logic [WCW-1:0]      wcnt_q;
	emsp_pkg::emsp_wkind_t wkind_q;
	logic [7:0]          pend_q;
	logic                arr_go_q;
	logic [7:0]          status_q;
	logic                hwp_q;

	logic                is_rd;
	logic                st_ok;
	logic                arr_ok;
	logic                done;
	logic [7:0]          view;

	assign hw_prot = hwpe_q & ~pin_lvl[IX_WP];
	assign is_rd   = op_is(op_q, `EMSP_OP_RD_STAT);

	// ----------------------------------------
	// Serial shift state
	// ----------------------------------------
	// Read status wraps its count so the register repeats without end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bitcnt_q <= 5'h00;
			op_q     <= 8'h00;
			dat_q    <= 8'h00;
		end else if (!cs_low) begin
			bitcnt_q <= 5'h00;
		end else if (sck_rise) begin
			if (bitcnt_q < 5'h08) begin
				op_q <= {op_q[6:0], pin_lvl[IX_SI]};
			end else begin
				dat_q <= {dat_q[6:0], pin_lvl[IX_SI]};
			end
			if (is_rd && bitcnt_q == 5'h0F) begin
				bitcnt_q <= 5'h08;
			end else if (bitcnt_q != 5'h10) begin
				bitcnt_q <= bitcnt_q + 5'h01;
			end
		end
	end

	// ----------------------------------------
	// Status view and output shifter
	// ----------------------------------------
	always_comb begin
		view                 = 8'h00;
		view[`EMSP_SR_LATCH] = latch_q;
		view[`EMSP_SR_BP_LO] = bp_q[0];
		view[`EMSP_SR_BP_HI] = bp_q[1];
		view[`EMSP_SR_HWPE]  = hwpe_q;
		if (busy_q) begin
			view = `EMSP_SR_BUSY_VIEW;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sout_q  <= 8'h00;
			rdout_q <= 1'b0;
		end else if (!cs_low) begin
			rdout_q <= 1'b0;
		end else if (sck_fall && is_rd && bitcnt_q >= 5'h08) begin
			rdout_q <= 1'b1;
			if (bitcnt_q[2:0] == 3'h0) begin
				sout_q <= view;
			end else begin
				sout_q <= {sout_q[6:0], 1'b0};
			end
		end
	end

	// Released in standby and during hold
	assign lnk.so    = sout_q[7];
	assign lnk.so_oe = rdout_q & cs_low & ~held;

	// ----------------------------------------
	// Instruction acceptance
	// ----------------------------------------
	// Busy gates every instruction but read status, which needs no frame action
	assign st_ok = frame_end & ~busy_q & (bitcnt_q == 5'h10)
		& op_is(op_q, `EMSP_OP_WR_STATUS)
		& latch_q & ~hw_prot;

	// Pin protection is not consulted for the array
	assign arr_ok = i_arr_req & ~busy_q & ~st_ok & latch_q
		& ~in_block(bp_q, i_arr_addr);

	assign done = busy_q & (wcnt_q == WCW'(P_WRITE_CYCLES - 1));

	// ----------------------------------------
	// Write enable latch
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_q <= 1'b0;
		end else if (done) begin
			latch_q <= 1'b0;
		end else if (frame_end && !busy_q && bitcnt_q == 5'h08) begin
			if (op_is(op_q, `EMSP_OP_SET_LATCH)) begin
				latch_q <= 1'b1;
			end else if (op_is(op_q, `EMSP_OP_CLR_LATCH)) begin
				latch_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Self-timed write cycle
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q  <= 1'b0;
			wcnt_q  <= '0;
			wkind_q <= emsp_pkg::WK_STATUS;
			pend_q  <= 8'h00;
		end else if (st_ok || arr_ok) begin
			busy_q  <= 1'b1;
			wcnt_q  <= '0;
			wkind_q <= st_ok ? emsp_pkg::WK_STATUS : emsp_pkg::WK_ARRAY;
			if (st_ok) begin
				pend_q <= dat_q;
			end
		end else if (done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			wcnt_q <= wcnt_q + WCW'(1);
		end
	end

	// ----------------------------------------
	// Protection bits
	// ----------------------------------------
	// Only the block and enable bits land, and only at completion
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bp_q   <= `EMSP_BP_RST;
			hwpe_q <= `EMSP_HWPE_RST;
		end else if (done && wkind_q == emsp_pkg::WK_STATUS) begin
			bp_q <= {pend_q[`EMSP_SR_BP_HI], pend_q[`EMSP_SR_BP_LO]};
			if (hwpe_q && !pin_lvl[IX_WP]) begin
				hwpe_q <= 1'b1;
			end else begin
				hwpe_q <= pend_q[`EMSP_SR_HWPE];
			end
		end
	end

	// ----------------------------------------
	// User-side outputs
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arr_go_q <= 1'b0;
			status_q <= 8'h00;
			hwp_q    <= 1'b0;
		end else begin
			arr_go_q <= arr_ok;
			status_q <= view;
			hwp_q    <= hw_prot;
		end
	end

	assign o_arr_go     = arr_go_q;
	assign o_busy       = busy_q;
	assign o_hw_protect = hwp_q;
	assign o_status     = status_q;
endmodule

//--- hdl/emsp_host_end.sv
// Bus master controller: AXI4-Lite registers driving the serial link
`timescale 1ns/1ps
`include "emsp_cfg.svh"
module emsp_host_end #(
	parameter int P_HALF = `EMSP_SCK_HALF_CYC
) (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// AXI4-Lite write channels
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [3:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic      [1:0]  o_bresp,
	// AXI4-Lite read channels
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [3:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic      [31:0] o_rdata,
	output logic      [1:0]  o_rresp,
	// Serial link
	emsp_link_if.host        lnk
);
	localparam int DW = $clog2(P_HALF + 1);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	logic                       aw_have_q;
	logic [3:0]                 aw_addr_q;
	logic                       w_have_q;
	logic [31:0]                w_data_q;
	logic [3:0]                 w_strb_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;
	logic                       rvalid_q;
	logic [31:0]                rdata_q;
	logic [1:0]                 rresp_q;
	logic [16:0]                cmd_q;
	logic [1:0]                 pins_q;
	emsp_pkg::emsp_host_state_t state_q;
	logic [DW-1:0]              div_q;
	logic                       sck_q;
	logic                       cs_n_q;
	logic [15:0]                tx_q;
	logic [4:0]                 cnt_q;
	logic [7:0]                 rx_q;
	logic                       hold_q;
	logic                       so_s;
	logic                       do_wr;
	logic                       idle;
	logic                       start;
	logic                       wrap;
	logic [31:0]                cmd_new;

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	assign idle      = (state_q == emsp_pkg::HST_IDLE);
	assign do_wr     = aw_have_q & w_have_q & ~bvalid_q;
	assign start     = do_wr & (aw_addr_q == `EMSP_REG_CMD) & idle;
	assign cmd_new   = merge(32'(cmd_q), w_data_q, w_strb_q);
	assign o_awready = ~aw_have_q & ~bvalid_q;
	assign o_wready  = ~w_have_q & ~bvalid_q;
	assign o_arready = ~rvalid_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end else if (do_wr) begin
				aw_have_q <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
			end else if (do_wr) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Command written while a frame runs is refused with an error
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `EMSP_RESP_OK;
			cmd_q    <= 17'h00000;
			pins_q   <= `EMSP_PINS_RST;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (start || aw_addr_q == `EMSP_REG_PINS) ? `EMSP_RESP_OK : `EMSP_RESP_ERR;
			if (start) begin
				cmd_q <= cmd_new[16:0];
			end
			if (aw_addr_q == `EMSP_REG_PINS) begin
				pins_q <= 2'(merge(32'(pins_q), w_data_q, w_strb_q));
			end
		end else if (i_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `EMSP_RESP_OK;
		end else if (i_arvalid && o_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `EMSP_RESP_OK;
			unique case (i_araddr)
				`EMSP_REG_CMD:  rdata_q <= 32'(cmd_q);
				`EMSP_REG_STAT: rdata_q <= {16'h0000, rx_q, 7'h00, ~idle};
				`EMSP_REG_PINS: rdata_q <= {30'h0000_0000, pins_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `EMSP_RESP_ERR;
				end
			endcase
		end else if (i_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign o_bvalid = bvalid_q;
	assign o_bresp  = bresp_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata  = rdata_q;
	assign o_rresp  = rresp_q;

	// ----------------------------------------
	// Serial engine, mode 0
	// ----------------------------------------
	emsp_sync_edge #(
		.W       (1),
		.RST_VAL (1'b1)
	) u_so (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_async    (lnk.so_line),
		.o_level    (so_s),
		.o_rise     (),
		.o_fall     ()
	);

	assign wrap = (div_q == DW'(P_HALF - 1));

	// Output is sampled late in the high phase to cover the far end's delay
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= emsp_pkg::HST_IDLE;
			div_q   <= '0;
			sck_q   <= 1'b0;
			cs_n_q  <= 1'b1;
			tx_q    <= 16'h0000;
			cnt_q   <= 5'h00;
			rx_q    <= 8'h00;
		end else begin
			unique case (state_q)
				emsp_pkg::HST_IDLE: if (start) begin
					cs_n_q  <= 1'b0;
					// Opcode leaves first, data byte after it
					tx_q    <= {cmd_new[7:0], cmd_new[15:8]};
					cnt_q   <= 5'h00;
					div_q   <= '0;
					state_q <= emsp_pkg::HST_RUN;
				end
				emsp_pkg::HST_RUN: if (hold_q) begin
					div_q <= wrap ? '0 : div_q + DW'(1);
					if (wrap && !sck_q) begin
						sck_q <= 1'b1;
					end else if (wrap) begin
						sck_q <= 1'b0;
						rx_q  <= {rx_q[6:0], so_s};
						tx_q  <= {tx_q[14:0], 1'b0};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == (cmd_q[`EMSP_CMD_LONG] ? 5'h0F : 5'h07)) begin
							state_q <= emsp_pkg::HST_GAP;
						end
					end
				end
				emsp_pkg::HST_GAP: begin
					div_q <= wrap ? '0 : div_q + DW'(1);
					if (wrap) begin
						cs_n_q  <= 1'b1;
						state_q <= emsp_pkg::HST_TAIL;
					end
				end
				emsp_pkg::HST_TAIL: begin
					div_q <= wrap ? '0 : div_q + DW'(1);
					if (wrap) begin
						state_q <= emsp_pkg::HST_IDLE;
					end
				end
			endcase
		end
	end

	// Hold moves only while the clock is low and not rising on this edge
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= 1'b1;
		end else if (!sck_q && !(state_q == emsp_pkg::HST_RUN && wrap && hold_q)) begin
			hold_q <= pins_q[`EMSP_PINS_HOLD];
		end
	end

	assign lnk.cs_n   = cs_n_q;
	assign lnk.sck    = sck_q;
	assign lnk.si     = tx_q[15];
	assign lnk.hold_n = hold_q;
	assign lnk.wp_n   = pins_q[`EMSP_PINS_WP];
endmodule

//--- verification/emsp_link_props.sv
// Concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
module emsp_link_props (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Link signals
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_line
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("serial clock moved while deselected");
	cs_start_a: assert property ($fell(cs_n) |-> !sck [*4] ##1 sck)
		else $error("first clock rise not four cycles after select");
	sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("clock high phase not four cycles");
	si_fall_a: assert property ($changed(si) |-> $fell(sck) || $fell(cs_n) || cs_n)
		else $error("data in changed away from a falling clock");
	hold_clk_a: assert property ($changed(hold_n) |-> !sck)
		else $error("hold moved while clock high");
	hold_freeze_a: assert property (!hold_n |-> !sck)
		else $error("clock ran during hold");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("deselect gap shorter than four cycles");
	cs_tail_a: assert property ($rose(cs_n) |-> !$past(sck, 4) && $past(sck, 5))
		else $error("deselect not four cycles after last fall");
	standby_a: assert property (cs_n [*4] |-> !so_oe)
		else $error("data out driven in standby");
	hold_off_a: assert property (!hold_n [*4] |-> !so_oe)
		else $error("data out driven during hold");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	frame_c: cover property ($rose(cs_n));
	hold_c: cover property ($fell(hold_n) && !cs_n);
	drive_c: cover property ($rose(so_oe));
	wp_c: cover property ($fell(wp_n));
endmodule

//--- verification/tb.sv
// Testbench for both ends of the serial EEPROM link
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, arr_req;
	logic        awready, wready, bvalid, arready, rvalid, arr_go, busy, hwp;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [9:0]  arr_addr;
	logic [7:0]  status;
	int          err_count, num_checks, go_cnt, m_latch, m_bp, m_pe, m_busy;
	logic [7:0]  ops [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
	logic [9:0]  adr [4] = '{10'h2FF, 10'h300, 10'h1FF, 10'h200};

	emsp_link_if lnk_if ();
	emsp_host_end u_emsp_host_end (.i_core_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.lnk(lnk_if.host));
	emsp_dev_end #(.P_WRITE_CYCLES(400)) u_emsp_dev_end (.i_core_clk(clk), .i_rst_n(rst_n),
		.lnk(lnk_if.dev), .i_arr_req(arr_req), .i_arr_addr(arr_addr), .o_arr_go(arr_go),
		.o_busy(busy), .o_hw_protect(hwp), .o_status(status));
	emsp_link_props u_emsp_link_props (.i_core_clk(clk), .i_rst_n(rst_n),
		.cs_n(lnk_if.cs_n), .sck(lnk_if.sck), .si(lnk_if.si), .hold_n(lnk_if.hold_n),
		.wp_n(lnk_if.wp_n), .so(lnk_if.so), .so_oe(lnk_if.so_oe), .so_line(lnk_if.so_line));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (arr_go === 1'h1) go_cnt <= go_cnt + 1;

	// ----------------------------------------
	// Model and helpers
	// ----------------------------------------
	function automatic logic [7:0] exp_sr();
		if (m_busy != 0) return 8'hFF;
		return {m_pe[0], 3'h0, m_bp[1:0], m_latch[0], 1'h0};
	endfunction
	function automatic int in_blk(int bp, int a);
		return bp == 3 || (bp == 1 && a >= 10'h300) || (bp == 2 && a >= 10'h200);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		awaddr <= a;
		wdata <= d;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		bready <= 1'h1;
		do @(posedge clk); while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'h1;
		araddr <= a;
		do @(posedge clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge clk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		logic [1:0]  r;
		do axr(4'h4, s, r); while (s[0] !== 1'h0);
	endtask
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input logic lng);
		logic [1:0] r;
		axw(4'h0, {15'h0, lng, dat, op}, r);
		chk(r, 2'h0);
		wait_idle();
	endtask
	task automatic sr_chk();
		logic [31:0] s;
		logic [1:0]  r;
		frame(8'h05, 8'h00, 1'h1);
		axr(4'h4, s, r);
		chk(s[15:8], exp_sr());
		chk(status, exp_sr());
	endtask
	task automatic wait_dev();
		while (busy !== 1'h0) @(posedge clk);
		@(posedge clk);
	endtask
	task automatic pins(input logic [31:0] v);
		logic [1:0] r;
		axw(4'h8, v, r);
		chk(r, 2'h0);
		repeat (6) @(posedge clk);
	endtask
	task automatic arr_try(input logic [9:0] a, input int go);
		int g;
		g = go_cnt;
		@(posedge clk);
		arr_req <= 1'h1;
		arr_addr <= a;
		@(posedge clk);
		arr_req <= 1'h0;
		repeat (2) @(posedge clk);
		chk(go_cnt - g, go);
		if (go != 0) begin
			wait_dev();
			m_latch = 0;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  v;
		logic [9:0]  a;
		{awvalid, wvalid, bready, arvalid, rready, arr_req} = 6'h0;
		{awaddr, araddr, wdata, arr_addr} = 50'h0;
		wstrb = 4'hF;
		rst_n = 1'h0;
		void'($urandom(83106));
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		chk(status, 8'h00);
		chk(hwp, 1'h0);
		axr(4'h8, d, r);
		chk(d, 32'h3);
		axr(4'hC, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		axw(4'h4, 32'h0, r);
		chk(r, 2'h2);
		frame(8'h01, 8'h8C, 1'h1);
		sr_chk();
		for (int i = 0; i < 4; i++) begin
			frame(ops[i], 8'h00, 1'h0);
			m_latch = ops[i][1];
			sr_chk();
		end
		frame(8'h06, 8'h00, 1'h0);
		m_latch = 1;
		// Stray bits in the written byte must be dropped
		v = 8'h8C | 8'($urandom() & 32'h73);
		axw(4'h0, {16'h1, v, 8'h01}, r);
		axw(4'h0, 32'h10005, r);
		chk(r, 2'h2);
		wait_idle();
		m_busy = 1;
		chk(busy, 1'h1);
		sr_chk();
		arr_try(10'h000, 0);
		wait_dev();
		m_busy = 0;
		m_latch = 0;
		m_bp = 3;
		m_pe = 1;
		sr_chk();
		pins(32'h2);
		chk(hwp, 1'h1);
		frame(8'h06, 8'h00, 1'h0);
		m_latch = 1;
		frame(8'h01, 8'h00, 1'h1);
		sr_chk();
		for (int b = 0; b < 4; b++) begin
			pins(32'h3);
			frame(8'h06, 8'h00, 1'h0);
			frame(8'h01, {1'h1, 3'h0, b[1:0], 2'h0}, 1'h1);
			wait_dev();
			m_latch = 0;
			m_bp = b;
			m_pe = 1;
			// Pin protection on: the array must stay writable outside the block
			pins(32'h2);
			arr_try(10'h3FF, 0);
			for (int k = 0; k < 5; k++) begin
				a = (k < 4) ? adr[k] : 10'($urandom());
				frame(8'h06, 8'h00, 1'h0);
				m_latch = 1;
				arr_try(a, !in_blk(b, a));
			end
			sr_chk();
		end
		pins(32'h3);
		axw(4'h0, 32'h10005, r);
		repeat (30) @(posedge clk);
		pins(32'h1);
		repeat (40) @(posedge clk);
		pins(32'h3);
		wait_idle();
		axr(4'h4, d, r);
		chk(d[15:8], exp_sr());
		results();
	end

	initial begin
		#(40 * 60000);
		err_count++;
		results();
	end
endmodule
